// File: rtl/ccs_params.svh
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// Register offsets of the command port
`define CCS_OFF_CTRL 8'h00
`define CCS_OFF_CMD 8'h04
`define CCS_OFF_STAT 8'h08

// Control word fields
`define CCS_CTRL_DIV_LSB 0
`define CCS_CTRL_FREQ_LSB 4
`define CCS_CTRL_AUTO_BIT 8
`define CCS_CTRL_SUBOK_BIT 9
`define CCS_CTRL_RESET 16'h0000

// Clock output mode fields and values
`define CCS_OMODE_EN_BIT 3
`define CCS_OMODE_ZERO_BIT 2
`define CCS_OMODE_RESET 4'h0
`define CCS_OMODE_CPU 4'h8

// Divider encodings
`define CCS_DIV_FX16 2'h1
`define CCS_DIV_SAFE 2'h0

// Port 2 settings for clock output
`define CCS_PORT2_LATCH_LOW 4'h0
`define CCS_PORT2_OUTPUT 4'hF

// Timing
`define CCS_CLK_NS 8
`define CCS_STARTUP_NS 31300000
`define CCS_SUB_MC_NS 122000
`define CCS_SWITCH_MC 32
`define CCS_STARTUP_CYC \
   ((`CCS_STARTUP_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_SWITCH_CYC \
   ((`CCS_SWITCH_MC * `CCS_SUB_MC_NS + `CCS_CLK_NS - 1) / `CCS_CLK_NS)
`define CCS_CNT_W 22

`endif

// File: rtl/ccs_pkg.sv
`default_nettype none
package ccs_pkg;
   typedef enum logic [12:0] {
      ST_BOOT      = 13'h0001,
      ST_IDLE      = 13'h0002,
      ST_SUB_DIV   = 13'h0004,
      ST_SUB_SEL   = 13'h0008,
      ST_SUB_WAIT  = 13'h0010,
      ST_SUB_STOP  = 13'h0020,
      ST_MAIN_OSC  = 13'h0040,
      ST_MAIN_WAIT = 13'h0080,
      ST_MAIN_SEL  = 13'h0100,
      ST_CO_FREQ   = 13'h0200,
      ST_CO_LATCH  = 13'h0400,
      ST_CO_MODE   = 13'h0800,
      ST_CO_EN     = 13'h1000
   } ccs_st_t;

   typedef enum logic [2:0] {
      DA_CPU_DIV      = 3'h0,
      DA_SYS_SEL      = 3'h1,
      DA_OSC_STOP     = 3'h2,
      DA_CLK_OUT_MODE = 3'h3,
      DA_PORT2_LATCH  = 3'h4,
      DA_PORT2_MODE   = 3'h5
   } ccs_dev_addr_t;

   typedef enum logic [2:0] {
      CMD_NONE    = 3'h0,
      CMD_GO_SUB  = 3'h1,
      CMD_GO_MAIN = 3'h2,
      CMD_SET_DIV = 3'h3,
      CMD_CO_START = 3'h4,
      CMD_BURST_ON = 3'h5,
      CMD_BURST_OFF = 3'h6,
      CMD_CLR_ERR = 3'h7
   } ccs_cmd_t;
endpackage
`default_nettype wire

// File: rtl/ccs_axil.sv
`include "ccs_params.svh"
`default_nettype none
module ccs_axil (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Core side
   input wire logic [15:0] status,
   output logic [15:0] ctrl,
   output logic cmd_valid,
   output ccs_pkg::ccs_cmd_t cmd
);
   typedef struct packed {
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ctrl;
      logic cmd_valid;
      ccs_pkg::ccs_cmd_t cmd;
   } ccs_bus_t;

   ccs_bus_t q, d;
   logic wr_go;

   // Address and data are taken together, only once the response is gone
   assign wr_go = awvalid && wvalid && !q.bvalid;
   assign awready = wr_go;
   assign wready = wr_go;
   assign arready = !q.rvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rdata = q.rdata;
   assign rresp = q.rresp;
   assign ctrl = q.ctrl;
   assign cmd_valid = q.cmd_valid;
   assign cmd = q.cmd;

   always_comb begin
      d = q;
      d.cmd_valid = 1'b0;
      if (q.bvalid && bready) begin
         d.bvalid = 1'b0;
      end
      if (wr_go) begin
         d.bvalid = 1'b1;
         d.bresp = 2'h0;
         case (awaddr)
            `CCS_OFF_CTRL: begin
               if (wstrb[0]) begin
                  d.ctrl[7:0] = wdata[7:0];
               end
               if (wstrb[1]) begin
                  d.ctrl[15:8] = wdata[15:8];
               end
            end
            `CCS_OFF_CMD: begin
               d.cmd_valid = wstrb[0];
               d.cmd = ccs_pkg::ccs_cmd_t'(wdata[2:0]);
            end
            `CCS_OFF_STAT: begin
               d.bresp = 2'h0;
            end
            default: begin
               d.bresp = 2'h2;
            end
         endcase
      end
      if (q.rvalid && rready) begin
         d.rvalid = 1'b0;
      end
      if (arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = 2'h0;
         case (araddr)
            `CCS_OFF_CTRL: d.rdata = {16'h0000, q.ctrl};
            `CCS_OFF_CMD: d.rdata = 32'h0000_0000;
            `CCS_OFF_STAT: d.rdata = {16'h0000, status};
            default: begin
               d.rdata = 32'h0000_0000;
               d.rresp = 2'h2;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '{bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
                rdata: 32'h0000_0000, rresp: 2'h0,
                ctrl: `CCS_CTRL_RESET, cmd_valid: 1'b0,
                cmd: ccs_pkg::CMD_NONE};
      end else if (ce) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// File: rtl/ccs_ctrl.sv
// Functional notes
// - Stop main oscillation only after the switchover time has elapsed.
// - Never select subsystem clock while divider holds divide-by-16.
// - Never program divide-by-16 while running on subsystem clock.
// - Main to subsystem switch takes 32 machine cycles; wait before stop.
// - Subsystem oscillator must run before it is selected.
// - Restore: restart oscillator, wait stabilisation, then select main.
// - Raise divider speed only after starting at reset speed.
// - Clock output start: frequency, latch zero, port output, enable.
// - Bit 2 of clock output mode is always written as zero.
// - Frequency bits set the carrier; enable bit gates bursts.
`include "ccs_params.svh"
`default_nettype none
module ccs_ctrl #(
   parameter int STARTUP_CYC = `CCS_STARTUP_CYC,
   parameter int SWITCH_CYC = `CCS_SWITCH_CYC,
   parameter int STAB_CYC = `CCS_STARTUP_CYC
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // AXI4-Lite slave
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Power fail pin
   input wire logic power_fail_interrupt,
   // Device register write port
   output logic dev_we,
   output ccs_pkg::ccs_dev_addr_t dev_addr,
   output logic [3:0] dev_wdata,
   // Status
   output logic busy
);
   localparam int CW = `CCS_CNT_W;

   typedef struct packed {
      ccs_pkg::ccs_st_t st;
      logic [CW-1:0] cnt;
      logic [1:0] div;
      logic sub;
      logic osc_off;
      logic [3:0] omode;
      logic port_ok;
      logic boot_done;
      logic err;
      logic we;
      ccs_pkg::ccs_dev_addr_t addr;
      logic [3:0] data;
      logic [2:0] pf;
   } ccs_state_t;

   ccs_state_t q, d;
   logic [15:0] ctrl;
   logic [15:0] status;
   logic cmd_valid;
   ccs_pkg::ccs_cmd_t cmd;
   ccs_pkg::ccs_cmd_t go;
   logic [1:0] req_div;
   logic [1:0] req_freq;

   ccs_axil u_bus (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .status(status),
      .ctrl(ctrl),
      .cmd_valid(cmd_valid),
      .cmd(cmd)
   );

   // Device writes are one-cycle strobes from flip-flops
   function automatic ccs_state_t put(input ccs_state_t s,
                                      input ccs_pkg::ccs_dev_addr_t a,
                                      input logic [3:0] v);
      s.we = 1'b1;
      s.addr = a;
      s.data = v;
      return s;
   endfunction

   function automatic logic [3:0] omode_val(input logic en,
                                            input logic [1:0] f);
      return {en, 1'b0, f};
   endfunction

   assign req_div = ctrl[`CCS_CTRL_DIV_LSB +: 2];
   assign req_freq = ctrl[`CCS_CTRL_FREQ_LSB +: 2];
   assign dev_we = q.we;
   assign dev_addr = q.addr;
   assign dev_wdata = q.data;
   assign busy = (q.st != ccs_pkg::ST_IDLE);
   // Shadow of the write-only mode register, since the device cannot read back
   assign status = {3'h0, q.err, q.boot_done, q.port_ok, q.sub, q.osc_off,
                    busy, q.omode, q.div, 1'b0};

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.we = 1'b0;
      // Pin passes two flops before the edge detector looks at it
      d.pf = {q.pf[1:0], power_fail_interrupt};
      go = ccs_pkg::CMD_NONE;
      if (cmd_valid) begin
         go = cmd;
      end else if (q.pf[1] && !q.pf[2] && ctrl[`CCS_CTRL_AUTO_BIT] &&
                   !q.sub && !q.osc_off) begin
         go = ccs_pkg::CMD_GO_SUB;
      end
      if (go == ccs_pkg::CMD_CLR_ERR) begin
         d.err = 1'b0;
      end else if (go != ccs_pkg::CMD_NONE && busy) begin
         // Commands while busy are dropped and flagged; a clear is never flagged and always clears
         d.err = 1'b1;
      end
      case (q.st)
         ccs_pkg::ST_BOOT: begin
            d.cnt = q.cnt + CW'(1);
            if (q.cnt == CW'(STARTUP_CYC - 1)) begin
               d.boot_done = 1'b1;
               d.st = ccs_pkg::ST_IDLE;
            end
         end
         ccs_pkg::ST_IDLE: begin
            case (go)
               ccs_pkg::CMD_GO_SUB: begin
                  if (q.sub || !ctrl[`CCS_CTRL_SUBOK_BIT]) begin
                     d.err = 1'b1;
                  end else if (q.div == `CCS_DIV_FX16) begin
                     d.st = ccs_pkg::ST_SUB_DIV;
                  end else begin
                     d.st = ccs_pkg::ST_SUB_SEL;
                  end
               end
               ccs_pkg::CMD_GO_MAIN: begin
                  if (!q.sub) begin
                     d.err = 1'b1;
                  end else begin
                     d.st = ccs_pkg::ST_MAIN_OSC;
                  end
               end
               ccs_pkg::CMD_SET_DIV: begin
                  if (q.sub && req_div == `CCS_DIV_FX16) begin
                     d.err = 1'b1;
                  end else begin
                     d = put(d, ccs_pkg::DA_CPU_DIV, {2'h0, req_div});
                     d.div = req_div;
                  end
               end
               ccs_pkg::CMD_CO_START: begin
                  d.st = ccs_pkg::ST_CO_FREQ;
               end
               ccs_pkg::CMD_BURST_ON,
               ccs_pkg::CMD_BURST_OFF: begin
                  if (!q.port_ok) begin
                     d.err = 1'b1;
                  end else begin
                     d.omode = omode_val(go == ccs_pkg::CMD_BURST_ON,
                                         q.omode[1:0]);
                     d = put(d, ccs_pkg::DA_CLK_OUT_MODE, d.omode);
                  end
               end
               default: begin
                  d.st = ccs_pkg::ST_IDLE;
               end
            endcase
         end
         ccs_pkg::ST_SUB_DIV: begin
            d = put(d, ccs_pkg::DA_CPU_DIV, {2'h0, `CCS_DIV_SAFE});
            d.div = `CCS_DIV_SAFE;
            d.st = ccs_pkg::ST_SUB_SEL;
         end
         ccs_pkg::ST_SUB_SEL: begin
            // device lags; count from the select write
            d = put(d, ccs_pkg::DA_SYS_SEL, 4'h1);
            d.sub = 1'b1;
            d.cnt = '0;
            d.st = ccs_pkg::ST_SUB_WAIT;
         end
         ccs_pkg::ST_SUB_WAIT: begin
            d.cnt = q.cnt + CW'(1);
            if (q.cnt == CW'(SWITCH_CYC - 1)) begin
               d.st = ccs_pkg::ST_SUB_STOP;
            end
         end
         ccs_pkg::ST_SUB_STOP: begin
            d = put(d, ccs_pkg::DA_OSC_STOP, 4'h1);
            d.osc_off = 1'b1;
            d.st = ccs_pkg::ST_IDLE;
         end
         ccs_pkg::ST_MAIN_OSC: begin
            d = put(d, ccs_pkg::DA_OSC_STOP, 4'h0);
            d.osc_off = 1'b0;
            d.cnt = '0;
            d.st = ccs_pkg::ST_MAIN_WAIT;
         end
         ccs_pkg::ST_MAIN_WAIT: begin
            d.cnt = q.cnt + CW'(1);
            if (q.cnt == CW'(STAB_CYC - 1)) begin
               d.st = ccs_pkg::ST_MAIN_SEL;
            end
         end
         ccs_pkg::ST_MAIN_SEL: begin
            d = put(d, ccs_pkg::DA_SYS_SEL, 4'h0);
            d.sub = 1'b0;
            d.st = ccs_pkg::ST_IDLE;
         end
         ccs_pkg::ST_CO_FREQ: begin
            d.omode = omode_val(1'b0, req_freq);
            d = put(d, ccs_pkg::DA_CLK_OUT_MODE, d.omode);
            d.port_ok = 1'b0;
            d.st = ccs_pkg::ST_CO_LATCH;
         end
         ccs_pkg::ST_CO_LATCH: begin
            // low latch keeps idle pin low
            d = put(d, ccs_pkg::DA_PORT2_LATCH, `CCS_PORT2_LATCH_LOW);
            d.st = ccs_pkg::ST_CO_MODE;
         end
         ccs_pkg::ST_CO_MODE: begin
            d = put(d, ccs_pkg::DA_PORT2_MODE, `CCS_PORT2_OUTPUT);
            d.port_ok = 1'b1;
            d.st = ccs_pkg::ST_CO_EN;
         end
         ccs_pkg::ST_CO_EN: begin
            // frequency 0 with enable gives 1000B
            d.omode = omode_val(1'b1, q.omode[1:0]);
            d = put(d, ccs_pkg::DA_CLK_OUT_MODE, d.omode);
            d.st = ccs_pkg::ST_IDLE;
         end
         default: begin
            d.st = ccs_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '{st: ccs_pkg::ST_BOOT, cnt: '0, div: 2'h0, sub: 1'b0,
                osc_off: 1'b0, omode: `CCS_OMODE_RESET, port_ok: 1'b0,
                boot_done: 1'b0, err: 1'b0, we: 1'b0,
                addr: ccs_pkg::DA_CPU_DIV, data: 4'h0, pf: 3'h0};
      end else if (ce) begin
         q <= d;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Checks sample only enabled edges, so frozen cycles are invisible
   default clocking cb @(posedge clk iff ce);
   endclocking
   default disable iff (!nrst);

   AST_BIT2_ZERO: assert property (
      dev_we && dev_addr == ccs_pkg::DA_CLK_OUT_MODE
      |-> dev_wdata[`CCS_OMODE_ZERO_BIT] == 1'b0)
      else $error("clock output mode written with bit 2 set");
   AST_NO_SUB_AT_DIV16: assert property (
      dev_we && dev_addr == ccs_pkg::DA_SYS_SEL && dev_wdata[0]
      |-> $past(q.div) != `CCS_DIV_FX16)
      else $error("subsystem selected at divide-by-16");
   AST_NO_DIV16_ON_SUB: assert property (
      dev_we && dev_addr == ccs_pkg::DA_CPU_DIV && $past(q.sub)
      |-> dev_wdata[1:0] != `CCS_DIV_FX16)
      else $error("divide-by-16 written on subsystem clock");
   AST_STOP_AFTER_SWITCH: assert property (
      dev_we && dev_addr == ccs_pkg::DA_OSC_STOP && dev_wdata[0]
      |-> q.cnt == CW'(SWITCH_CYC) && q.sub)
      else $error("main oscillator stopped before switchover");
   AST_MAIN_AFTER_STAB: assert property (
      dev_we && dev_addr == ccs_pkg::DA_SYS_SEL && !dev_wdata[0]
      |-> q.cnt == CW'(STAB_CYC) && !q.osc_off)
      else $error("main clock selected before stabilisation");
   AST_DIV_AFTER_BOOT: assert property (
      dev_we |-> q.boot_done && $past(q.boot_done))
      else $error("device written during start-up wait");
   AST_BOOT_LENGTH: assert property (
      $rose(q.boot_done) |-> $past(q.cnt) == CW'(STARTUP_CYC - 1))
      else $error("start-up wait has wrong length");
   AST_MODE_AFTER_LATCH: assert property (
      dev_we && dev_addr == ccs_pkg::DA_PORT2_MODE
      |-> $past(dev_we && dev_addr == ccs_pkg::DA_PORT2_LATCH &&
                dev_wdata == `CCS_PORT2_LATCH_LOW))
      else $error("port mode set before latch cleared");
   AST_ENABLE_LAST: assert property (
      dev_we && dev_addr == ccs_pkg::DA_CLK_OUT_MODE &&
      dev_wdata[`CCS_OMODE_EN_BIT] |-> q.port_ok)
      else $error("clock output enabled before port setup");
   AST_BURST_KEEPS_FREQ: assert property (
      dev_we && dev_addr == ccs_pkg::DA_CLK_OUT_MODE && q.port_ok &&
      $past(q.port_ok)
      |-> dev_wdata[1:0] == $past(q.omode[1:0]))
      else $error("burst gating changed carrier frequency");

   COV_POWER_FAIL: cover property (
      dev_we && dev_addr == ccs_pkg::DA_OSC_STOP && dev_wdata[0]);
   COV_RESTORE: cover property (
      dev_we && dev_addr == ccs_pkg::DA_SYS_SEL && !dev_wdata[0]);
   COV_CPU_CLOCK_OUT: cover property (
      dev_we && dev_addr == ccs_pkg::DA_CLK_OUT_MODE &&
      dev_wdata == `CCS_OMODE_CPU);
   COV_BURST_OFF: cover property (
      dev_we && dev_addr == ccs_pkg::DA_CLK_OUT_MODE &&
      !dev_wdata[`CCS_OMODE_EN_BIT] && $past(q.port_ok));
endmodule
`default_nettype wire

// File: verification/ccs_dev_model.sv
`default_nettype none
module ccs_dev_model #(
   parameter int SWITCH_CYC = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Device write port
   input wire logic dev_we,
   input wire logic [2:0] dev_addr,
   input wire logic [3:0] dev_wdata,
   // Observed device state
   output logic [23:0] regs_q,
   output logic [27:0] hist_q,
   output int gap_q,
   output logic viol_q,
   output logic clock_output_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   logic ph_q;
   logic gate_q;
   logic [2:0] a;
   logic [3:0] d;
   assign a = dev_addr;
   assign d = dev_wdata;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!nrst) begin
         regs_q <= 24'h0;
         hist_q <= 28'h0;
         gap_q <= 0;
         cnt_q <= 0;
         viol_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 1;
         if (dev_we) begin
            regs_q[a*4 +: 4] <= d;
            hist_q <= {hist_q[20:0], a, d};
            gap_q <= cnt_q;
            cnt_q <= 1;
            if ((a == 3'h1 && d[0] && regs_q[3:0] == 4'h1) ||
                (a == 3'h0 && d == 4'h1 && regs_q[4]) ||
                (a == 3'h3 && d[2]) ||
                (a == 3'h3 && d[3] && regs_q[23:16] != 8'hF0) ||
                (a == 3'h2 && d[0] && (!regs_q[4] || cnt_q < SWITCH_CYC)) ||
                (a == 3'h1 && !d[0] && regs_q[8]))
               viol_q <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // gate moves only while low
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ph_q <= 1'b0;
         gate_q <= 1'b0;
      end else begin
         ph_q <= ~ph_q;
         if (!ph_q)
            gate_q <= regs_q[15] && regs_q[23:16] == 8'hF0;
      end
   end
   // enabled mode puts CPU clock out once port 2 latch is low and port 2 is output
   assign clock_output_pin = ph_q & gate_q;
endmodule
`default_nettype wire

// File: verification/test_cpu_clock_switch_and_clock_output.sv
`default_nettype none
module test_cpu_clock_switch_and_clock_output;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SW = 10;
   localparam int STAB = 20;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, pfi = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, dev_we, busy, pin;
   logic viol, p;
   logic [1:0] bresp, rresp, wr;
   ccs_pkg::ccs_dev_addr_t dev_addr;
   logic [3:0] dev_wdata;
   logic [3:0] wstrb = 4'hF;
   logic [23:0] regs;
   logic [27:0] hist;
   int gap;
   int fails = 0, checked = 0;
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   ccs_ctrl #(.STARTUP_CYC(20), .SWITCH_CYC(SW), .STAB_CYC(STAB)) dut (
      .clk(clk), .nrst(nrst), .ce(ce), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .power_fail_interrupt(pfi), .dev_we(dev_we),
      .dev_addr(dev_addr), .dev_wdata(dev_wdata), .busy(busy));
   ccs_dev_model #(.SWITCH_CYC(SW)) dev (
      .clk(clk), .nrst(nrst), .dev_we(dev_we), .dev_addr(dev_addr),
      .dev_wdata(dev_wdata), .regs_q(regs), .hist_q(hist),
      .gap_q(gap), .viol_q(viol), .clock_output_pin(pin));
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic give_verdict;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      logic aw_on, w_on;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_on = 1'b1;
      w_on = 1'b1;
      // Each channel is released at its own handshake
      while (aw_on || w_on) begin
         @(posedge clk);
         if (aw_on && awready === 1'b1) begin
            aw_on = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_on && wready === 1'b1) begin
            w_on = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      wr = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd32(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rd = rdata;
      wr = rresp;
      rready <= 1'b0;
   endtask
   task automatic idle;
      repeat (6) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
      // Last device write lands in the model one edge after busy drops
      @(posedge clk);
   endtask
   task automatic cmd(input ccs_pkg::ccs_cmd_t c);
      wr32(8'h04, {29'h0, c});
      idle();
   endtask
   task automatic err(input logic e);
      rd32(8'h08);
      check("err", rd[12], e);
      if (e)
         cmd(ccs_pkg::CMD_CLR_ERR);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      check("busy", busy, 1'b1);
      rd32(8'h08);
      check("boot", rd[11], 1'b0);
      cmd(ccs_pkg::CMD_SET_DIV);
      check("hist", hist, 28'h0);
      err(1'b1);
      check("done", rd[11], 1'b1);
      cmd(ccs_pkg::CMD_BURST_ON);
      err(1'b1);
      wstrb <= 4'h0;
      wr32(8'h04, 32'h5);
      wstrb <= 4'hF;
      idle();
      err(1'b0);
      rd32(8'h40);
      check("rresp", wr, 2'h2);
      check("rdata", rd, 32'h0);
      wr32(8'h40, 32'h5);
      check("bresp", wr, 2'h2);
      rd32(8'h04);
      check("cmd", rd, 32'h0);
      wr32(8'h00, 32'h3);
      rd32(8'h00);
      check("ctrl", rd, 32'h3);
      cmd(ccs_pkg::CMD_SET_DIV);
      check("div", regs[3:0], 4'h3);
      wr32(8'h00, 32'h1);
      cmd(ccs_pkg::CMD_SET_DIV);
      cmd(ccs_pkg::CMD_GO_SUB);
      check("sel", regs[7:4], 4'h0);
      err(1'b1);
      wr32(8'h00, 32'h201);
      wr32(8'h04, 32'h1);
      wr32(8'h04, 32'h3);
      idle();
      check("hist", hist[20:0], {3'h0, 4'h0, 3'h1, 4'h1, 3'h2, 4'h1});
      check("gap", gap >= SW + 1, 1'b1);
      err(1'b1);
      cmd(ccs_pkg::CMD_SET_DIV);
      check("div", regs[3:0], 4'h0);
      err(1'b1);
      cmd(ccs_pkg::CMD_GO_MAIN);
      check("hist", hist[13:0], {3'h2, 4'h0, 3'h1, 4'h0});
      check("gap", gap >= STAB + 1, 1'b1);
      wr32(8'h00, 32'h200);
      cmd(ccs_pkg::CMD_CO_START);
      check("co", hist, {3'h3, 4'h0, 3'h4, 4'h0, 3'h5, 4'hF, 3'h3, 4'h8});
      repeat (3) @(posedge clk);
      p = pin;
      @(posedge clk);
      check("pin", pin, !p);
      cmd(ccs_pkg::CMD_BURST_OFF);
      check("mode", regs[15:12], 4'h0);
      check("pin", pin, 1'b0);
      cmd(ccs_pkg::CMD_BURST_ON);
      check("mode", regs[15:12], 4'h8);
      wr32(8'h00, 32'h300);
      pfi <= 1'b1;
      idle();
      pfi <= 1'b0;
      check("pfail", regs[11:4], 8'h11);
      check("viol", viol, 1'b0);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      check("rst", {busy, dev_we}, 2'b10);
      nrst <= 1'b1;
      ce <= 1'b0;
      repeat (30) @(posedge clk);
      check("freeze", busy, 1'b1);
      ce <= 1'b1;
      rd32(8'h00);
      check("ctrl", rd, 32'h0);
      rd32(8'h08);
      check("omode", rd[6:3], 4'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
